// ===== bench/agu_assertions.sv
// concurrent checks on the operand address generator ports
`timescale 1ns/1ps
`default_nettype none
module agu_checker
  import agu_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic reset, // async reset
  input wire logic clk_en, // advance
  input wire logic req_valid, // request
  input wire agu_mode_e req_mode, // mode
  input wire logic [2:0] req_ptr_sel, // pointer select
  input wire logic req_prog_space, // program target
  input wire logic [5:0] req_field6, // short field
  input wire logic [6:0] req_field7, // signed field
  input wire imm_kind_e req_imm_kind, // immediate kind
  input wire logic [15:0] ext_word, // extension word
  input wire logic stall, // stall
  input wire logic addr_valid, // address strobe
  input wire logic [15:0] data_addr, // data address
  input wire logic data_sel, // data space
  input wire logic prog_sel, // program space
  input wire logic [15:0] prog_addr, // program address
  input wire logic [15:0] imm_operand, // immediate
  input wire logic imm_valid, // immediate strobe
  input wire logic [1:0] ext_words, // words consumed
  input wire logic [15:0] pointer_two, // pointer 2
  input wire logic [15:0] pointer_three, // pointer 3
  input wire logic [15:0] stack_pointer, // stack pointer
  input wire logic [15:0] offset_reg, // offset
  input wire logic [15:0] address_modifier_reg // modifier
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic take = req_valid && !stall && clk_en;

  post_dec_a: assert property (take && req_mode == MODE_POST_DEC && req_ptr_sel == 3'h2
    |=> addr_valid && data_sel && data_addr == $past(pointer_two) && pointer_two == $past(pointer_two) - 16'h0001)
    else $error("post-decrement address or write-back wrong");
  post_off_a: assert property (take && req_mode == MODE_POST_OFFSET && req_ptr_sel == 3'h3
    |=> addr_valid && ($past(req_prog_space) ? prog_sel && prog_addr == $past(pointer_three)
    : data_sel && data_addr == $past(pointer_three))
    && pointer_three == $past(pointer_three) + $past(offset_reg) && offset_reg == $past(offset_reg))
    else $error("post-update by offset wrong");
  stall_wait_a: assert property (take && req_mode inside {MODE_INDEX_OFFSET, MODE_SHORT_DISP}
    |=> stall ##1 stall ##1 (addr_valid && !stall))
    else $error("one-cycle wait not kept");
  index_off_a: assert property (take && req_mode == MODE_INDEX_OFFSET && req_ptr_sel == 3'h2
    |-> ##3 data_addr == $past(pointer_two, 3) + $past(offset_reg, 3) && pointer_two == $past(pointer_two, 3))
    else $error("indexed address wrong");
  short_disp_a: assert property (take && req_mode == MODE_SHORT_DISP && req_ptr_sel inside {3'h2, 3'h4}
    |-> ##3 data_sel && data_addr == ($past(req_ptr_sel, 3) == 3'h4
    ? $past(stack_pointer, 3) + {10'h3FF, $past(req_field6, 3)} : $past(pointer_two, 3) + {10'h000, $past(req_field6, 3)}))
    else $error("short displacement wrong");
  long_disp_a: assert property (take && req_mode == MODE_LONG_DISP && req_ptr_sel == 3'h2
    |=> stall[*3] ##1 (addr_valid && data_addr == $past(pointer_two, 4) + $past(ext_word, 4)))
    else $error("long displacement wrong");
  imm_long_a: assert property (take && req_mode == MODE_IMM_LONG
    |=> imm_valid && prog_sel && ext_words == 2'h1 && imm_operand == $past(ext_word))
    else $error("immediate word wrong");
  imm_short_a: assert property (take && req_mode == MODE_IMM_SHORT |=> imm_valid && imm_operand ==
    ($past(req_imm_kind) == IMM_LOOP_COUNT ? {10'h000, $past(req_field6)} : {{9{$past(req_field7[6])}}, $past(req_field7)}))
    else $error("short immediate wrong");
  abs_long_a: assert property (take && req_mode == MODE_ABS_LONG |=> ext_words == 2'h1
    ##2 (addr_valid && data_sel && prog_sel && data_addr == $past(ext_word, 3)))
    else $error("absolute address wrong");
  abs_short_a: assert property (take && req_mode inside {MODE_ABS_SHORT, MODE_IO_SHORT} |=> addr_valid &&
    data_sel && data_addr == {($past(req_mode) == MODE_IO_SHORT ? 10'h3FF : 10'h000), $past(req_field6)})
    else $error("short absolute address wrong");
  mod_reset_a: assert property ($fell(reset) |-> address_modifier_reg == 16'hFFFF && offset_reg == 16'h0000)
    else $error("modifier not linear after reset");
endmodule : agu_checker

bind operand_address_generator agu_checker chk (.core_clk, .reset, .clk_en, .req_valid, .req_mode,
  .req_ptr_sel, .req_prog_space, .req_field6, .req_field7, .req_imm_kind, .ext_word, .stall,
  .addr_valid, .data_addr, .data_sel, .prog_sel, .prog_addr, .imm_operand, .imm_valid, .ext_words,
  .pointer_two, .pointer_three, .stack_pointer, .offset_reg, .address_modifier_reg);
`default_nettype wire

// ===== bench/mem_side_model.sv
// memory-side observer counting data accesses and peripheral-window hits
`timescale 1ns/1ps
`default_nettype none
module mem_side_model (
  input wire logic core_clk, // clock
  input wire logic addr_valid, // access strobe
  input wire logic data_sel, // data space
  input wire logic [15:0] data_addr, // data address
  output int data_hits, // data accesses seen
  output int io_hits // accesses in top 64 words
);
  int data_cnt = 0;
  int io_cnt = 0;
  assign data_hits = data_cnt;
  assign io_hits = io_cnt;
  always @(posedge core_clk) begin
    if (addr_valid && data_sel) begin
      data_cnt <= data_cnt + 1;
    end
    // peripherals answer only in the top 64 words; elsewhere software uses other modes
    if (addr_valid && data_sel && data_addr[15:6] == 10'h3FF) begin
      io_cnt <= io_cnt + 1;
    end
  end
endmodule : mem_side_model
`default_nettype wire

// ===== bench/test_operand_address_generator.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module test_operand_address_generator
  import agu_pkg::*;
;
  logic core_clk, reset, clk_en, req_valid, req_prog_space, ptr_wr_en, offset_wr_en, modifier_wr_en;
  agu_mode_e req_mode;
  imm_kind_e req_imm_kind;
  logic [2:0] req_ptr_sel, ptr_wr_sel;
  logic [5:0] req_field6;
  logic [6:0] req_field7;
  logic [15:0] ext_word, ptr_wr_data, reg_wr_data, data_addr, prog_addr, imm_operand;
  logic [15:0] pointer_zero, pointer_one, pointer_two, pointer_three, stack_pointer;
  logic [15:0] offset_reg, address_modifier_reg;
  logic stall, addr_valid, data_sel, prog_sel, imm_valid;
  logic [1:0] ext_words;
  int bad_count, checks_done, data_hits, io_hits, lat;

  operand_address_generator uut (.core_clk, .reset, .clk_en, .req_valid, .req_mode, .req_ptr_sel,
    .req_prog_space, .req_field6, .req_field7, .req_imm_kind, .ext_word, .ptr_wr_en, .ptr_wr_sel,
    .ptr_wr_data, .offset_wr_en, .modifier_wr_en, .reg_wr_data, .stall, .addr_valid, .data_addr,
    .data_sel, .prog_sel, .prog_addr, .imm_operand, .imm_valid, .ext_words, .pointer_zero,
    .pointer_one, .pointer_two, .pointer_three, .stack_pointer, .offset_reg, .address_modifier_reg);
  mem_side_model mem (.core_clk, .addr_valid, .data_sel, .data_addr, .data_hits, .io_hits);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_ptr(input logic [2:0] sel, input logic [15:0] val);
    @(posedge core_clk);
    #1;
    ptr_wr_en = 1'b1;
    ptr_wr_sel = sel;
    ptr_wr_data = val;
    @(posedge core_clk);
    #1;
    ptr_wr_en = 1'b0;
  endtask : wr_ptr

  // modif high loads the modifier, low loads the offset
  task wr_reg(input logic modif, input logic [15:0] val);
    @(posedge core_clk);
    #1;
    offset_wr_en = !modif;
    modifier_wr_en = modif;
    reg_wr_data = val;
    @(posedge core_clk);
    #1;
    offset_wr_en = 1'b0;
    modifier_wr_en = 1'b0;
  endtask : wr_reg

  // one request, then a bounded wait for the address or immediate strobe; lat counts edges
  task send(input agu_mode_e m, input logic [2:0] sel, input logic [5:0] f6, input logic [15:0] ext);
    @(posedge core_clk);
    #1;
    req_mode = m;
    req_ptr_sel = sel;
    req_field6 = f6;
    ext_word = ext;
    req_valid = 1'b1;
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    lat = 1;
    while (addr_valid !== 1'b1 && imm_valid !== 1'b1 && lat < 8) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    if (addr_valid !== 1'b1 && imm_valid !== 1'b1) begin
      bad_count++;
      close_out;
    end
  endtask : send

  task t_post_dec;
    wr_reg(1'b0, 16'h0007);
    wr_ptr(3'h2, 16'h0005);
    send(MODE_POST_DEC, 3'h2, 6'h00, 16'h0000);
    chk(data_addr, 16'h0005);
    chk(pointer_two, 16'h0004);
    chk(16'(lat), 16'h0001);
    send(MODE_POST_DEC, 3'h0, 6'h00, 16'h1234);
    chk(data_addr, 16'h0000);
    chk(pointer_zero, 16'hFFFF);
  endtask : t_post_dec

  task t_post_off;
    wr_reg(1'b0, 16'hFFFE);
    wr_ptr(3'h3, 16'h0010);
    send(MODE_POST_OFFSET, 3'h3, 6'h00, 16'h0000);
    chk(data_addr, 16'h0010);
    chk(pointer_three, 16'h000E);
    chk(offset_reg, 16'hFFFE);
    chk(16'(lat), 16'h0001);
    req_prog_space = 1'b1;
    send(MODE_POST_OFFSET, 3'h3, 6'h00, 16'h0000);
    req_prog_space = 1'b0;
    chk(prog_addr, 16'h000E);
    chk({15'h0000, prog_sel}, 16'h0001);
    chk(pointer_three, 16'h000C);
  endtask : t_post_off

  task t_index;
    wr_reg(1'b0, 16'h0005);
    wr_ptr(3'h2, 16'h0100);
    send(MODE_INDEX_OFFSET, 3'h2, 6'h00, 16'h0000);
    chk(data_addr, 16'h0105);
    chk(pointer_two, 16'h0100);
    chk(offset_reg, 16'h0005);
    chk(16'(lat), 16'h0003);
  endtask : t_index

  task t_disp;
    wr_ptr(3'h4, 16'h0200);
    send(MODE_SHORT_DISP, 3'h4, 6'h02, 16'h0000);
    chk(data_addr, 16'h01C2);
    chk({15'h0000, data_sel}, 16'h0001);
    chk(16'(lat), 16'h0003);
    send(MODE_SHORT_DISP, 3'h2, 6'h3F, 16'h0000);
    chk(data_addr, 16'h013F);
    // modulo enabled for the first two pointers must not touch pointer_two
    wr_reg(1'b1, 16'h000F);
    send(MODE_LONG_DISP, 3'h2, 6'h00, 16'hFF00);
    chk(data_addr, 16'h0000);
    chk(16'(lat), 16'h0004);
    // 16-word circular window at 0x0010: stepping below its base wraps to its top
    wr_ptr(3'h1, 16'h0010);
    send(MODE_POST_DEC, 3'h1, 6'h00, 16'h0000);
    chk(data_addr, 16'h0010);
    chk(pointer_one, 16'h001F);
    wr_reg(1'b1, 16'hFFFF);
  endtask : t_disp

  task t_imm;
    send(MODE_IMM_LONG, 3'h0, 6'h00, 16'hA987);
    chk(imm_operand, 16'hA987);
    chk({15'h0000, prog_sel}, 16'h0001);
    chk({14'h0000, ext_words}, 16'h0001);
    req_imm_kind = IMM_LOOP_COUNT;
    send(MODE_IMM_SHORT, 3'h0, 6'h3F, 16'h0000);
    chk(imm_operand, 16'h003F);
    req_imm_kind = IMM_CORE_MOVE;
    req_field7 = 7'h40;
    send(MODE_IMM_SHORT, 3'h0, 6'h3F, 16'h0000);
    chk(imm_operand, 16'hFFC0);
  endtask : t_imm

  task t_abs;
    send(MODE_ABS_LONG, 3'h0, 6'h00, 16'h5079);
    chk(data_addr, 16'h5079);
    chk(16'(lat), 16'h0003);
    send(MODE_ABS_SHORT, 3'h0, 6'h03, 16'hFFFF);
    chk(data_addr, 16'h0003);
    send(MODE_IO_SHORT, 3'h0, 6'h3B, 16'h0000);
    chk(data_addr, 16'hFFFB);
  endtask : t_abs

  initial begin
    {reset, clk_en} = 2'h3;
    {req_valid, req_prog_space, ptr_wr_en, offset_wr_en, modifier_wr_en} = 5'h00;
    {req_ptr_sel, ptr_wr_sel, req_field6, req_field7} = 19'h00000;
    {ext_word, ptr_wr_data, reg_wr_data} = 48'h0;
    req_mode = MODE_POST_DEC;
    req_imm_kind = IMM_LOOP_COUNT;
    bad_count = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    chk(address_modifier_reg, 16'hFFFF);
    chk(pointer_zero, 16'h0000);
    t_post_dec;
    t_post_off;
    t_index;
    t_disp;
    t_imm;
    t_abs;
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'(data_hits), 16'h000B);
    chk(16'(io_hits), 16'h0001);
    close_out;
  end
endmodule : test_operand_address_generator
`default_nettype wire

// ===== rtl/agu_adder.sv
// pointer adder: 16-bit linear sum, or modulo wrap when a modifier selects it
`timescale 1ns/1ps
`default_nettype none
module agu_adder #(
  parameter int W = 16
) (
  input wire logic [W-1:0] base, // unsigned pointer value
  input wire logic [W-1:0] offset, // signed two's-complement offset
  input wire logic [W-1:0] modifier, // all ones selects linear
  input wire logic use_mod, // this pointer may use the modifier
  output logic [W-1:0] sum // resulting address
);
  logic [W-1:0] lin;
  logic [W-1:0] modulus;
  logic [W-1:0] lower;
  logic [W-1:0] upper;
  logic [W-1:0] wrapped;
  logic modulo_on;
  always_comb begin
    lin = base + offset;
    modulus = modifier + {{(W-1){1'b0}}, 1'b1};
    // buffer base: clear bits below the modulus size; simple power-of-two window
    lower = base & ~(modulus - {{(W-1){1'b0}}, 1'b1});
    upper = lower + modifier;
    wrapped = lin;
    if (!offset[W-1] && (lin > upper)) begin
      wrapped = lin - modulus;
    end else if (offset[W-1] && (lin < lower)) begin
      wrapped = lin + modulus;
    end
    modulo_on = use_mod && (modifier != {W{1'b1}});
    sum = modulo_on ? wrapped : lin;
  end
endmodule : agu_adder
`default_nettype wire

// ===== rtl/agu_defs.svh
// address generator constants: reset values, register selects, field widths, cycle costs
`ifndef AGU_DEFS_SVH
`define AGU_DEFS_SVH
`define AGU_ADDR_W 16
`define AGU_SHORT_W 6
`define AGU_IMM7_W 7
`define AGU_LINEAR_MOD 16'hFFFF
`define AGU_PTR_RESET 16'h0000
`define AGU_OFFSET_RESET 16'h0000
`define AGU_STACK_RESET 16'h0000
`define AGU_EXTRA_NONE 2'h0
`define AGU_EXTRA_ONE 2'h1
`define AGU_EXTRA_TWO 2'h2
`define AGU_SEL_P0 3'h0
`define AGU_SEL_P1 3'h1
`define AGU_SEL_P2 3'h2
`define AGU_SEL_P3 3'h3
`define AGU_SEL_STACK 3'h4
`define AGU_CORE_CLK_MHZ 125
`endif

// ===== rtl/agu_operand_field.sv
// short opcode field extension for displacements, short addresses and immediates
`timescale 1ns/1ps
`default_nettype none
module agu_operand_field #(
  parameter int W = 16
) (
  input wire logic [5:0] field6, // 6-bit opcode field
  input wire logic [6:0] field7, // 7-bit signed immediate field
  output logic [W-1:0] zero_ext, // zero-extended field6
  output logic [W-1:0] one_ext, // one-extended field6
  output logic [W-1:0] sign_ext7 // sign-extended field7
);
  always_comb begin
    zero_ext = {{(W-6){1'b0}}, field6};
    one_ext = {{(W-6){1'b1}}, field6};
    sign_ext7 = {{(W-7){field7[6]}}, field7};
  end
endmodule : agu_operand_field
`default_nettype wire

// ===== rtl/agu_pkg.sv
// address generator types: addressing modes and sequencer states
`default_nettype none
package agu_pkg;
  typedef enum logic [3:0] {
    MODE_POST_DEC = 4'h0,
    MODE_POST_OFFSET = 4'h1,
    MODE_INDEX_OFFSET = 4'h2,
    MODE_SHORT_DISP = 4'h3,
    MODE_LONG_DISP = 4'h4,
    MODE_IMM_LONG = 4'h5,
    MODE_IMM_SHORT = 4'h6,
    MODE_ABS_LONG = 4'h7,
    MODE_ABS_SHORT = 4'h8,
    MODE_IO_SHORT = 4'h9
  } agu_mode_e;
  typedef enum logic [1:0] {
    IMM_LOOP_COUNT = 2'h0,
    IMM_CORE_MOVE = 2'h1
  } imm_kind_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ISSUE = 3'b100
  } seq_state_e;
endpackage : agu_pkg
`default_nettype wire

// ===== rtl/operand_address_generator.sv
// operand address generator: effective address, pointer write-back and stall accounting
// How it works
// - post-decrement addresses at the pointer, then writes pointer minus one, ignoring offset.
// - pointer_zero/one follow address_modifier_reg; pointer_two/three and stack_pointer are linear.
// - post-update by offset addresses at the pointer then adds signed offset_reg, no extra cycle.
// - indexed by offset addresses pointer plus offset, costs one cycle, updates nothing.
// - short displacement one-extends with stack_pointer and zero-extends with pointer_two.
// - short displacement is always linear, costs one cycle and targets data memory.
// - long displacement adds a signed extension word under the modifier rule, costing two cycles.
// - immediate data is one 16-bit extension word taken as a program memory reference.
// - short immediates are 6-bit unsigned for loop counts and 7-bit signed for core moves.
// - absolute address uses a 16-bit extension word, one cycle and one program word.
// - absolute short zero-extends six bits into the lowest 64 data locations.
// - I/O short one-extends six bits into the highest 64 data locations.
// - post-update by offset also serves program memory accesses with the same update.
// - linear math is 16-bit two's complement, addresses unsigned, offsets signed.
// - address_modifier_reg holding all ones selects linear and resets to all ones.
`timescale 1ns/1ps
`default_nettype none
`include "agu_defs.svh"
module operand_address_generator
  import agu_pkg::*;
#(
  parameter int W = `AGU_ADDR_W
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, active high
  input wire logic clk_en, // freezes all state when low
  input wire logic req_valid, // decoder presents an operand request
  input wire agu_mode_e req_mode, // addressing mode
  input wire logic [2:0] req_ptr_sel, // pointer select
  input wire logic req_prog_space, // post-update access aimed at program memory
  input wire logic [5:0] req_field6, // 6-bit opcode field
  input wire logic [6:0] req_field7, // 7-bit signed immediate field
  input wire imm_kind_e req_imm_kind, // short immediate kind
  input wire logic [W-1:0] ext_word, // instruction extension word
  input wire logic ptr_wr_en, // register-direct load of a pointer
  input wire logic [2:0] ptr_wr_sel, // which pointer to load
  input wire logic [W-1:0] ptr_wr_data, // load value
  input wire logic offset_wr_en, // load offset_reg
  input wire logic modifier_wr_en, // load address_modifier_reg
  input wire logic [W-1:0] reg_wr_data, // data for offset/modifier load
  output logic stall, // holds the pipeline for extra cycles
  output logic addr_valid, // effective address presented this cycle
  output logic [W-1:0] data_addr, // data memory address
  output logic data_sel, // access goes to data memory
  output logic prog_sel, // access/operand is a program reference
  output logic [W-1:0] prog_addr, // program memory address
  output logic [W-1:0] imm_operand, // immediate operand value
  output logic imm_valid, // immediate operand presented
  output logic [1:0] ext_words, // extension words consumed
  output logic [W-1:0] pointer_zero, // pointer register 0
  output logic [W-1:0] pointer_one, // pointer register 1
  output logic [W-1:0] pointer_two, // pointer register 2
  output logic [W-1:0] pointer_three, // pointer register 3
  output logic [W-1:0] stack_pointer, // stack pointer
  output logic [W-1:0] offset_reg, // shared offset register
  output logic [W-1:0] address_modifier_reg // modifier register
);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  logic [W-1:0] ptr_r [5];
  logic [W-1:0] ptr_nxt [5];
  logic [W-1:0] offset_r, offset_nxt;
  logic [W-1:0] mod_r, mod_nxt;
  seq_state_e state_r, state_nxt;
  logic [1:0] wait_r, wait_nxt;
  agu_mode_e mode_r, mode_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [W-1:0] ea_r, ea_nxt;
  logic [W-1:0] ext_r, ext_nxt;
  logic [W-1:0] data_addr_r, data_addr_nxt;
  logic [W-1:0] prog_addr_r, prog_addr_nxt;
  logic [W-1:0] imm_r, imm_nxt;
  logic addr_valid_r, addr_valid_nxt;
  logic data_sel_r, data_sel_nxt;
  logic prog_sel_r, prog_sel_nxt;
  logic imm_valid_r, imm_valid_nxt;
  logic [1:0] ext_words_r, ext_words_nxt;

  logic [W-1:0] base;
  logic [W-1:0] add_off;
  logic use_mod;
  logic [W-1:0] sum;
  logic [W-1:0] f_zero, f_one, f_sext7;
  logic [2:0] cur_sel;
  agu_mode_e cur_mode;
  logic [W-1:0] cur_ext;

  agu_operand_field #(.W(W)) u_field (
    .field6(req_field6),
    .field7(req_field7),
    .zero_ext(f_zero),
    .one_ext(f_one),
    .sign_ext7(f_sext7)
  );

  // a single adder serves both the effective address and the post-update, in the request cycle
  agu_adder #(.W(W)) u_adder (
    .base(base),
    .offset(add_off),
    .modifier(mod_r),
    .use_mod(use_mod),
    .sum(sum)
  );

  assign cur_sel = (state_r == ST_IDLE) ? req_ptr_sel : sel_r;
  assign cur_mode = (state_r == ST_IDLE) ? req_mode : mode_r;
  assign cur_ext = (state_r == ST_IDLE) ? ext_word : ext_r;

  always_comb begin
    base = ptr_r[(cur_sel > `AGU_SEL_STACK) ? `AGU_SEL_STACK : cur_sel];
    use_mod = (cur_sel == `AGU_SEL_P0) || (cur_sel == `AGU_SEL_P1);
    add_off = offset_r;
    case (cur_mode)
      MODE_POST_DEC: add_off = {W{1'b0}} - ONE;
      MODE_SHORT_DISP: begin
        use_mod = 1'b0;
        base = (cur_sel == `AGU_SEL_STACK) ? ptr_r[`AGU_SEL_STACK] : ptr_r[`AGU_SEL_P2];
        add_off = (cur_sel == `AGU_SEL_STACK) ? f_one : f_zero;
      end
      MODE_LONG_DISP: add_off = cur_ext;
      default: add_off = offset_r;
    endcase
  end

  // decode: effective address, pointer write-back and cycle cost
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ptr_nxt[i] = ptr_r[i];
    end
    offset_nxt = offset_r;
    mod_nxt = mod_r;
    state_nxt = state_r;
    wait_nxt = wait_r;
    mode_nxt = mode_r;
    sel_nxt = sel_r;
    ea_nxt = ea_r;
    ext_nxt = ext_r;
    data_addr_nxt = data_addr_r;
    prog_addr_nxt = prog_addr_r;
    imm_nxt = imm_r;
    addr_valid_nxt = 1'b0;
    data_sel_nxt = 1'b0;
    prog_sel_nxt = 1'b0;
    imm_valid_nxt = 1'b0;
    ext_words_nxt = `AGU_EXTRA_NONE;
    if (ptr_wr_en && ptr_wr_sel <= `AGU_SEL_STACK) begin
      ptr_nxt[ptr_wr_sel] = ptr_wr_data;
    end
    if (offset_wr_en) begin
      offset_nxt = reg_wr_data;
    end
    if (modifier_wr_en) begin
      mod_nxt = reg_wr_data;
    end
    case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          mode_nxt = req_mode;
          sel_nxt = req_ptr_sel;
          ext_nxt = ext_word;
          case (req_mode)
            MODE_POST_DEC, MODE_POST_OFFSET: begin
              // address is the old pointer; write-back carries the sum
              addr_valid_nxt = 1'b1;
              if (req_prog_space && req_mode == MODE_POST_OFFSET) begin
                prog_sel_nxt = 1'b1;
                prog_addr_nxt = base;
              end else begin
                data_sel_nxt = 1'b1;
                data_addr_nxt = base;
              end
              if (req_ptr_sel <= `AGU_SEL_STACK) begin
                ptr_nxt[req_ptr_sel] = sum;
              end
            end
            MODE_INDEX_OFFSET, MODE_SHORT_DISP: begin
              ea_nxt = sum;
              wait_nxt = `AGU_EXTRA_ONE;
              state_nxt = ST_WAIT;
            end
            MODE_LONG_DISP: begin
              ea_nxt = sum;
              wait_nxt = `AGU_EXTRA_TWO;
              ext_words_nxt = `AGU_EXTRA_ONE;
              state_nxt = ST_WAIT;
            end
            MODE_ABS_LONG: begin
              ea_nxt = ext_word;
              wait_nxt = `AGU_EXTRA_ONE;
              ext_words_nxt = `AGU_EXTRA_ONE;
              state_nxt = ST_WAIT;
            end
            MODE_IMM_LONG: begin
              imm_nxt = ext_word;
              imm_valid_nxt = 1'b1;
              prog_sel_nxt = 1'b1;
              ext_words_nxt = `AGU_EXTRA_ONE;
            end
            MODE_IMM_SHORT: begin
              imm_nxt = (req_imm_kind == IMM_LOOP_COUNT) ? f_zero : f_sext7;
              imm_valid_nxt = 1'b1;
              prog_sel_nxt = 1'b1;
            end
            MODE_ABS_SHORT: begin
              data_addr_nxt = f_zero;
              data_sel_nxt = 1'b1;
              addr_valid_nxt = 1'b1;
            end
            MODE_IO_SHORT: begin
              // peripherals outside the top window need another mode
              data_addr_nxt = f_one;
              data_sel_nxt = 1'b1;
              addr_valid_nxt = 1'b1;
            end
            default: begin
              state_nxt = ST_IDLE;
            end
          endcase
        end
      end
      ST_WAIT: begin
        wait_nxt = wait_r - `AGU_EXTRA_ONE;
        if (wait_r == `AGU_EXTRA_ONE) begin
          state_nxt = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // data-memory presentation after the stall cycles; pointers untouched
        data_addr_nxt = ea_r;
        data_sel_nxt = 1'b1;
        addr_valid_nxt = 1'b1;
        prog_sel_nxt = (mode_r == MODE_ABS_LONG);
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 5; i++) begin
        ptr_r[i] <= `AGU_PTR_RESET;
      end
      offset_r <= `AGU_OFFSET_RESET;
      mod_r <= `AGU_LINEAR_MOD;
      state_r <= ST_IDLE;
      wait_r <= `AGU_EXTRA_NONE;
      mode_r <= MODE_POST_DEC;
      sel_r <= `AGU_SEL_P0;
      ea_r <= '0;
      ext_r <= '0;
      data_addr_r <= '0;
      prog_addr_r <= '0;
      imm_r <= '0;
      addr_valid_r <= 1'b0;
      data_sel_r <= 1'b0;
      prog_sel_r <= 1'b0;
      imm_valid_r <= 1'b0;
      ext_words_r <= `AGU_EXTRA_NONE;
    end else if (clk_en) begin
      for (int i = 0; i < 5; i++) begin
        ptr_r[i] <= ptr_nxt[i];
      end
      offset_r <= offset_nxt;
      mod_r <= mod_nxt;
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      mode_r <= mode_nxt;
      sel_r <= sel_nxt;
      ea_r <= ea_nxt;
      ext_r <= ext_nxt;
      data_addr_r <= data_addr_nxt;
      prog_addr_r <= prog_addr_nxt;
      imm_r <= imm_nxt;
      addr_valid_r <= addr_valid_nxt;
      data_sel_r <= data_sel_nxt;
      prog_sel_r <= prog_sel_nxt;
      imm_valid_r <= imm_valid_nxt;
      ext_words_r <= ext_words_nxt;
    end
  end

  // stall is combinational so the decoder holds its next request
  assign stall = (state_r != ST_IDLE);
  assign addr_valid = addr_valid_r;
  assign data_addr = data_addr_r;
  assign data_sel = data_sel_r;
  assign prog_sel = prog_sel_r;
  assign prog_addr = prog_addr_r;
  assign imm_operand = imm_r;
  assign imm_valid = imm_valid_r;
  assign ext_words = ext_words_r;
  assign pointer_zero = ptr_r[0];
  assign pointer_one = ptr_r[1];
  assign pointer_two = ptr_r[2];
  assign pointer_three = ptr_r[3];
  assign stack_pointer = ptr_r[4];
  assign offset_reg = offset_r;
  assign address_modifier_reg = mod_r;
endmodule : operand_address_generator
`default_nettype wire
